//--- src/sppx_pkg.sv
// Package for the serial port parameter exchange block.
// Assumes a 50 MHz pclk and an APB register bus with 32-bit data.
package sppx_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_TXD = 8'h08;
  localparam logic [7:0] ADDR_RXD = 8'h0C;
  localparam logic [7:0] ADDR_IRQ = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  localparam logic [7:0] ADDR_VER = 8'h18;
  localparam logic [7:0] ADDR_PCHK = 8'h1C;
  localparam int unsigned NUM_RATES = 9;
  localparam logic [17:0] RATE_DIV [NUM_RATES] = '{
    18'(CLK_HZ / 300), 18'(CLK_HZ / 600), 18'(CLK_HZ / 1200), 18'(CLK_HZ / 2400),
    18'(CLK_HZ / 4800), 18'(CLK_HZ / 9600), 18'(CLK_HZ / 19200), 18'(CLK_HZ / 34800),
    18'(CLK_HZ / 57600)};
  localparam logic [3:0] RATE_RESET = 4'h5;
  localparam logic [7:0] CHAR_XON = 8'h11;
  localparam logic [7:0] CHAR_XOFF = 8'h13;
  localparam logic [7:0] CHAR_EOF = 8'h1A;
  localparam int unsigned DATA_BITS = 8;
  localparam logic [7:0] SW_VERSION = 8'h01;
  // Status and interrupt bit positions
  localparam int unsigned EV_RXDONE = 0;
  localparam int unsigned EV_TXDONE = 1;
  localparam int unsigned EV_FRAME = 2;
  localparam int unsigned EV_OVERRUN = 3;
  localparam int unsigned EV_VERFAULT = 4;
  localparam int unsigned EV_SKIP = 5;
  localparam int unsigned EV_FILE_DONE = 6;
  localparam int unsigned NUM_EV = 7;
  typedef enum logic [1:0] {
    USE_FILE, USE_LEADER, USE_FOLLOWER, USE_TEXT
  } sppx_use_e;
  typedef enum logic [1:0] {
    XFER_IDLE, XFER_UPLOAD, XFER_DOWNLOAD
  } sppx_xfer_e;
  typedef struct packed {
    logic [3:0] rate;
    sppx_use_e use_sel;
    logic edit_mode;
    sppx_xfer_e xfer;
    logic restore;
    logic upload_end;
  } sppx_ctrl_s;
endpackage

//--- src/sppx_top.sv
// Serial port with XON/XOFF parameter file transfer and APB registers.
// Assumes rxd is synchronous to pclk; APB master follows standard APB.
// Operation
// - Bit rate chosen among nine rates from 300 to 57,600 baud.
// - Port use code: 0 file, 1 leader, 2 follower, 3 text protocol.
// - Connection edit mode stops new transmit frames and idles the receiver until it is left.
// - File transfers pause on XOFF and resume on XON.
// - Text protocol runs receive and transmit at the same time.
// - Upload sends file to host, download accepts file from host.
// - Stored file from a newer software version raises a version fault.
// - Left-key acknowledge during fault restores factory defaults, clears fault.
// - Unknown parameter from tool path gives a warning and is skipped.
// - Characters framed 8 data bits, no parity, one stop bit.
// - Upload ends by sending CTRL-Z after the last record.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module sppx_top
  import sppx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic left_key,
  output logic txd,
  output logic irq,
  output logic defaults_load
);
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} sppx_tx_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} sppx_rx_e;

  sppx_ctrl_s ctrl, next_ctrl;
  logic [NUM_EV-1:0] stat, next_stat, mask, next_mask;
  logic [7:0] txbuf, next_txbuf, rxbuf, next_rxbuf, stored_ver, next_stored_ver;
  logic txfull, next_txfull, rxfull, next_rxfull, paused, next_paused;
  logic eof_pend, next_eof_pend, rdlatch_rx;
  logic [31:0] next_prdata;
  logic next_irq, next_defaults_load, next_txd;
  // Registered divisor keeps the rate mux off the counter reload paths
  logic [17:0] bdiv, next_bdiv;
  logic [17:0] rate_div;
  logic halted, wr_acc, rd_setup;
  logic [NUM_EV-1:0] ev;

  sppx_tx_e tx_st, next_tx_st;
  logic [17:0] tx_cnt, next_tx_cnt;
  logic [2:0] tx_bit, next_tx_bit;
  logic [7:0] tx_sh, next_tx_sh;
  logic tx_done;

  sppx_rx_e rx_st, next_rx_st;
  logic [17:0] rx_cnt, next_rx_cnt;
  logic [2:0] rx_bit, next_rx_bit;
  logic [7:0] rx_sh, next_rx_sh;
  logic rx_got, rx_ferr;

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  // Edit mode stops new frames; the receiver drops to idle at once
  assign halted = ctrl.edit_mode;
  assign rate_div = (ctrl.rate < 4'(NUM_RATES)) ? RATE_DIV[ctrl.rate]
    : RATE_DIV[RATE_RESET];
  // RXD read empties the buffer at setup; a byte landing then still wins
  assign rdlatch_rx = rd_setup && paddr == ADDR_RXD;

  ////////////////////////////////////////////////////////////////////
  // Transmitter, 8N1
  always_comb begin
    next_tx_st = tx_st;
    next_tx_cnt = tx_cnt;
    next_tx_bit = tx_bit;
    next_tx_sh = tx_sh;
    next_txd = txd;
    tx_done = 1'b0;
    // Loading waits while paused; a frame in flight always completes
    if (tx_st == TX_IDLE) begin
      next_txd = 1'b1;
      if (txfull && !paused && !halted) begin
        next_tx_st = TX_START;
        next_tx_sh = txbuf;
        next_tx_cnt = bdiv - 18'h00001;
        next_txd = 1'b0;
      end
    end else if (tx_cnt != 18'h00000) begin
      next_tx_cnt = tx_cnt - 18'h00001;
    end else begin
      next_tx_cnt = bdiv - 18'h00001;
      case (tx_st)
        TX_START: begin
          next_tx_st = TX_DATA;
          next_tx_bit = 3'h0;
          next_txd = tx_sh[0];
        end
        TX_DATA: begin
          if (tx_bit == 3'(DATA_BITS - 1)) begin
            next_tx_st = TX_STOP;
            next_txd = 1'b1;
          end else begin
            next_tx_bit = tx_bit + 3'h1;
            next_tx_sh = {1'b0, tx_sh[7:1]};
            next_txd = tx_sh[1];
          end
        end
        TX_STOP: begin
          next_tx_st = TX_IDLE;
          tx_done = 1'b1;
        end
        default: next_tx_st = TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receiver, runs independently of the transmitter
  always_comb begin
    next_rx_st = rx_st;
    next_rx_cnt = rx_cnt;
    next_rx_bit = rx_bit;
    next_rx_sh = rx_sh;
    rx_got = 1'b0;
    rx_ferr = 1'b0;
    if (halted) begin
      next_rx_st = RX_IDLE;
    end else if (rx_st == RX_IDLE) begin
      if (!rxd) begin
        next_rx_st = RX_START;
        next_rx_cnt = {1'b0, bdiv[17:1]};
      end
    end else if (rx_cnt != 18'h00000) begin
      next_rx_cnt = rx_cnt - 18'h00001;
    end else begin
      next_rx_cnt = bdiv - 18'h00001;
      case (rx_st)
        RX_START: begin
          next_rx_st = rxd ? RX_IDLE : RX_DATA;
          next_rx_bit = 3'h0;
        end
        RX_DATA: begin
          next_rx_sh = {rxd, rx_sh[7:1]};
          if (rx_bit == 3'(DATA_BITS - 1)) begin
            next_rx_st = RX_STOP;
          end
          next_rx_bit = rx_bit + 3'h1;
        end
        RX_STOP: begin
          next_rx_st = RX_IDLE;
          rx_got = rxd;
          rx_ferr = !rxd;
        end
        default: next_rx_st = RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers, flow control and events
  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_txbuf = txbuf;
    next_txfull = txfull;
    next_rxbuf = rxbuf;
    next_rxfull = rxfull;
    next_paused = paused;
    next_eof_pend = eof_pend;
    next_stored_ver = stored_ver;
    next_defaults_load = 1'b0;
    next_bdiv = rate_div;
    ev = '0;
    if (tx_st == TX_IDLE && txfull && !paused && !halted) begin
      next_txfull = 1'b0;
    end
    // CTRL-Z closes the upload once the last record has left
    if (eof_pend && !next_txfull && !txfull) begin
      next_txbuf = CHAR_EOF;
      next_txfull = 1'b1;
      next_eof_pend = 1'b0;
      ev[EV_FILE_DONE] = 1'b1;
    end
    if (rdlatch_rx) begin
      next_rxfull = 1'b0;
    end
    if (rx_got) begin
      // Flow characters steer the sender in file mode during a transfer; text mode passes all through
      if (ctrl.use_sel == USE_FILE && ctrl.xfer != XFER_IDLE
          && (rx_sh == CHAR_XOFF || rx_sh == CHAR_XON)) begin
        next_paused = (rx_sh == CHAR_XOFF);
      end else begin
        ev[EV_OVERRUN] = rxfull && !rdlatch_rx;
        next_rxbuf = rx_sh;
        next_rxfull = 1'b1;
        ev[EV_RXDONE] = 1'b1;
        if (ctrl.xfer == XFER_DOWNLOAD && rx_sh == CHAR_EOF) begin
          ev[EV_FILE_DONE] = 1'b1;
        end
      end
    end
    ev[EV_FRAME] = rx_ferr;
    ev[EV_TXDONE] = tx_done;
    if (ctrl.xfer == XFER_IDLE || ctrl.use_sel != USE_FILE) begin
      next_paused = 1'b0;
    end
    if (ctrl.upload_end) begin
      next_ctrl.upload_end = 1'b0;
    end
    if (ctrl.restore) begin
      next_ctrl.restore = 1'b0;
    end
    // Version fault stays up until acknowledged with the left key or the CTRL restore bit
    if (stored_ver > SW_VERSION) begin
      ev[EV_VERFAULT] = 1'b1;
      if (left_key || ctrl.restore) begin
        next_defaults_load = 1'b1;
        next_stored_ver = SW_VERSION;
        next_ctrl = '0;
        next_ctrl.rate = RATE_RESET;
      end
    end
    if (wr_acc) begin
      case (paddr)
        ADDR_CTRL: begin
          next_ctrl.rate = pwdata[3:0];
          next_ctrl.use_sel = sppx_use_e'(pwdata[5:4]);
          next_ctrl.edit_mode = pwdata[6];
          next_ctrl.xfer = sppx_xfer_e'(pwdata[9:8]);
          next_ctrl.restore = pwdata[10];
          next_ctrl.upload_end = pwdata[11];
          if (pwdata[11] && ctrl.xfer == XFER_UPLOAD) begin
            next_eof_pend = 1'b1;
          end
        end
        ADDR_TXD: begin
          if (!txfull) begin
            next_txbuf = pwdata[7:0];
            next_txfull = 1'b1;
          end
        end
        ADDR_MASK: next_mask = pwdata[NUM_EV-1:0];
        ADDR_VER: next_stored_ver = pwdata[7:0];
        ADDR_PCHK: ev[EV_SKIP] = pwdata[31];
        default: begin
        end
      endcase
    end
  end

  // Sticky status, write one to clear, set wins
  always_comb begin
    next_stat = stat;
    if (wr_acc && paddr == ADDR_IRQ) begin
      next_stat = stat & ~pwdata[NUM_EV-1:0];
    end
    next_stat = next_stat | ev;
    next_irq = |(next_stat & mask);
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    // Loaded in the setup phase so the data stands through the access phase
    if (rd_setup) begin
      case (paddr)
        ADDR_CTRL: next_prdata = {20'h00000, 1'b0, 1'b0, ctrl.xfer, 1'b0, ctrl.edit_mode,
                                  ctrl.use_sel, ctrl.rate};
        ADDR_STAT: next_prdata = {26'h0, stored_ver > SW_VERSION, eof_pend, paused,
                                  tx_st != TX_IDLE, rxfull, txfull};
        ADDR_RXD: next_prdata = {24'h000000, rxbuf};
        ADDR_IRQ: next_prdata = {25'h0, stat};
        ADDR_MASK: next_prdata = {25'h0, mask};
        ADDR_VER: next_prdata = {24'h000000, stored_ver};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '{rate: RATE_RESET, use_sel: USE_FILE, edit_mode: 1'b0, xfer: XFER_IDLE,
                restore: 1'b0, upload_end: 1'b0};
      stat <= '0;
      mask <= '0;
      txbuf <= 8'h00;
      rxbuf <= 8'h00;
      stored_ver <= SW_VERSION;
      txfull <= 1'b0;
      rxfull <= 1'b0;
      paused <= 1'b0;
      eof_pend <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      defaults_load <= 1'b0;
      txd <= 1'b1;
      bdiv <= RATE_DIV[RATE_RESET];
      tx_st <= TX_IDLE;
      tx_cnt <= 18'h00000;
      tx_bit <= 3'h0;
      tx_sh <= 8'h00;
      rx_st <= RX_IDLE;
      rx_cnt <= 18'h00000;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      stat <= next_stat;
      mask <= next_mask;
      txbuf <= next_txbuf;
      rxbuf <= next_rxbuf;
      stored_ver <= next_stored_ver;
      txfull <= next_txfull;
      rxfull <= next_rxfull;
      paused <= next_paused;
      eof_pend <= next_eof_pend;
      prdata <= next_prdata;
      pready <= 1'b1;
      pslverr <= 1'b0;
      irq <= next_irq;
      defaults_load <= next_defaults_load;
      txd <= next_txd;
      bdiv <= next_bdiv;
      tx_st <= next_tx_st;
      tx_cnt <= next_tx_cnt;
      tx_bit <= next_tx_bit;
      tx_sh <= next_tx_sh;
      rx_st <= next_rx_st;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_sh <= next_rx_sh;
    end
  end
endmodule

//--- tb/sppx_top_asserts.sv
// Checker bound to the serial port block top.
// Assumes serial traffic runs only at the fastest rate index.
`timescale 1ns/1ns
module sppx_top_asserts
  import sppx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic left_key,
  input wire logic txd,
  input wire logic irq,
  input wire logic defaults_load
);
  localparam int BITC = int'(RATE_DIV[8]);
  logic wr;
  logic edit_q;
  logic rst_wr;
  logic [NUM_EV-1:0] mask_q;
  int lowrun;
  assign wr = psel && penable && pwrite && pready;
  assign rst_wr = wr && paddr == ADDR_CTRL && pwdata[10];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edit_q <= 1'h0;
      mask_q <= '0;
      lowrun <= 0;
    end else begin
      if (wr && paddr == ADDR_CTRL) edit_q <= pwdata[6];
      if (wr && paddr == ADDR_MASK) mask_q <= pwdata[NUM_EV-1:0];
      lowrun <= txd ? 0 : lowrun + 1;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_ready_up;
    $past(presetn) |-> pready;
  endproperty
  a_ready_up: assert property (p_ready_up) else $error("pready low");
  property p_no_err;
    psel && penable |-> !pslverr;
  endproperty
  a_no_err: assert property (p_no_err) else $error("pslverr set");
  property p_rdata_idle;
    !(psel && !penable && !pwrite) |=> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not cleared");
  property p_unmapped;
    psel && !penable && !pwrite && paddr > ADDR_PCHK |=> prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_load_pulse;
    defaults_load |=> !defaults_load;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("reload too long");
  property p_load_cause;
    defaults_load |-> $past(left_key) || $past(rst_wr, 2);
  endproperty
  a_load_cause: assert property (p_load_cause) else $error("reload without key");
  property p_edit_halt;
    edit_q && $past(edit_q) |-> !$fell(txd);
  endproperty
  a_edit_halt: assert property (p_edit_halt) else $error("start in edit mode");
  property p_low_max;
    lowrun <= 9 * BITC + 1;
  endproperty
  a_low_max: assert property (p_low_max) else $error("txd low too long");
  property p_start_len;
    $rose(txd) |-> lowrun >= BITC - 2;
  endproperty
  a_start_len: assert property (p_start_len) else $error("low bit too short");
  property p_irq_mask;
    mask_q == 0 && $past(mask_q) == 0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
endmodule
bind sppx_top sppx_top_asserts u_sppx_top_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .left_key(left_key),
  .txd(txd), .irq(irq), .defaults_load(defaults_load));

//--- tb/sppx_host_model.sv
// Host side of the serial link: 8N1 sender and receiver.
// Assumes the device runs at the fastest rate index.
`timescale 1ns/1ns
module sppx_host_model
  import sppx_pkg::*;
#(
  parameter int BIT = int'(RATE_DIV[8])
)
(
  input wire logic pclk,
  input wire logic txd,
  output logic rxd
);
  logic [7:0] got_q[$];
  logic [7:0] sh;
  initial rxd = 1'h1;
  // Start, eight data bits low first, stop; flow characters go the same way
  task send(input logic [7:0] c);
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rxd <= (i == 0) ? 1'h0 : (i == 9) ? 1'h1 : c[i - 1];
      repeat (BIT - 1) @(posedge pclk);
    end
  endtask
  initial forever begin
    @(posedge pclk);
    if (txd === 1'h0) begin
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge pclk);
        sh[i] = txd;
      end
      repeat (BIT) @(posedge pclk);
      got_q.push_back(txd === 1'h1 ? sh : 8'hXX);
    end
  end
endmodule

//--- tb/tb.sv
// Bench: APB master, host model on the link, queue of expected characters.
// Assumes the host model and the bound checker sit beside the design.
`timescale 1ns/1ns
module tb;
  import sppx_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, left_key = 0;
  logic [7:0] paddr = 0;
  logic [7:0] b;
  logic [31:0] pwdata = 0, prdata, r, g;
  logic pready, pslverr, rxd, txd, irq, defaults_load;
  logic [7:0] q[$];
  int bad_count = 0, n_compared = 0, cyc = 0, loads = 0;
  always #10 pclk = ~pclk;
  sppx_top u_sppx_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .left_key(left_key), .txd(txd), .irq(irq),
    .defaults_load(defaults_load));
  sppx_host_model u_sppx_host_model (.pclk(pclk), .txd(txd), .rxd(rxd));
  task print_verdict;
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (defaults_load === 1'h1) loads <= loads + 1;
    if (cyc == 90000) begin
      bad_count = bad_count + 1;
      print_verdict();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task send_tx(input logic [7:0] c);
    apb(1'h1, ADDR_TXD, {24'h0, c});
    q.push_back(c);
  endtask
  task take_tx;
    int n;
    n = 0;
    while (u_sppx_host_model.got_q.size() == 0 && n < 12000) begin
      @(posedge pclk);
      n++;
    end
    g = 'x;
    if (u_sppx_host_model.got_q.size() > 0) g = {24'h0, u_sppx_host_model.got_q.pop_front()};
  endtask
  // Counts cycles in which txd is not at idle high
  task quiet(input int n);
    g = 0;
    repeat (n) begin
      @(posedge pclk);
      if (txd !== 1'h1) g = g + 1;
    end
  endtask
  initial begin
    void'($urandom(32'h856F));
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk(r, 32'h5);
    apb(1'h0, 8'h40, 32'h0);
    chk(r, 32'h0);
    for (int u = 0; u < 4; u++) begin
      apb(1'h1, ADDR_CTRL, 32'(u * 16 + 8));
      apb(1'h0, ADDR_CTRL, 32'h0);
      chk({30'h0, r[5:4]}, 32'(u));
    end
    apb(1'h1, ADDR_VER, 32'h2);
    apb(1'h0, ADDR_STAT, 32'h0);
    chk({31'h0, r[5]}, 32'h1);
    left_key <= 1'h1;
    repeat (3) @(posedge pclk);
    left_key <= 1'h0;
    repeat (2) @(posedge pclk);
    chk(32'(loads), 32'h1);
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk(r, 32'h5);
    apb(1'h0, ADDR_VER, 32'h0);
    chk(r, {24'h0, SW_VERSION});
    apb(1'h1, ADDR_VER, 32'h2);
    apb(1'h1, ADDR_CTRL, 32'h400);
    repeat (3) @(posedge pclk);
    chk(32'(loads), 32'h2);
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk(r, 32'h5);
    apb(1'h1, ADDR_PCHK, 32'h80000000);
    apb(1'h0, ADDR_IRQ, 32'h0);
    chk({31'h0, r[EV_SKIP]}, 32'h1);
    apb(1'h1, ADDR_MASK, 32'h2);
    apb(1'h1, ADDR_CTRL, 32'h108);
    send_tx(8'($urandom));
    take_tx();
    chk(g, {24'h0, q.pop_front()});
    repeat (600) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, ADDR_IRQ, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    u_sppx_host_model.send(CHAR_XOFF);
    send_tx(8'($urandom));
    quiet(5000);
    chk(g, 32'h0);
    u_sppx_host_model.send(CHAR_XON);
    take_tx();
    chk(g, {24'h0, q.pop_front()});
    apb(1'h1, ADDR_CTRL, 32'h908);
    q.push_back(CHAR_EOF);
    take_tx();
    chk(g, {24'h0, q.pop_front()});
    apb(1'h1, ADDR_CTRL, 32'h148);
    send_tx(8'($urandom));
    quiet(5000);
    chk(g, 32'h0);
    apb(1'h1, ADDR_CTRL, 32'h108);
    take_tx();
    chk(g, {24'h0, q.pop_front()});
    apb(1'h1, ADDR_CTRL, 32'h238);
    b = 8'($urandom);
    fork
      u_sppx_host_model.send(b);
      send_tx(8'($urandom));
    join
    take_tx();
    chk(g, {24'h0, q.pop_front()});
    apb(1'h0, ADDR_RXD, 32'h0);
    chk(r, {24'h0, b});
    apb(1'h0, ADDR_IRQ, 32'h0);
    chk({30'h0, r[EV_FILE_DONE], r[EV_RXDONE]}, 32'h3);
    print_verdict();
  end
endmodule
